// ===== bench/mdio_host.sv
`default_nettype none
// host model: drives the terminals, raises ready once power-up has passed
module mdio_host #(
   parameter int NTERM = 2,
   parameter int POWERUP_CYC = 20
) (
   input wire logic clk, // clock
   input wire logic rst, // async reset
   output var mdio_pkg::mdio_in_s in_pins, // operation terminals
   output var logic [NTERM-1:0] clamp_pins, // torque clamp terminals
   output var logic [NTERM-1:0] panel_pins, // panel unlock terminals
   output var logic [NTERM-1:0] ext_pins, // fault stop terminals
   output var logic ready // inputs may be relied on
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt_q;
   // count out power-up; commands sent earlier would be lost
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 0;
      end else if (cnt_q < POWERUP_CYC + 4) begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign ready = (cnt_q >= POWERUP_CYC + 4);
   // idle: run inputs off, normally closed terminals on
   initial begin
      in_pins = '0;
      clamp_pins = '1;
      panel_pins = '1;
      ext_pins = '1;
   end
   // levels change just after an edge, then hold
   task automatic put(input mdio_pkg::mdio_in_s v, input logic [3*NTERM-1:0] nc);
      @(posedge clk);
      #1;
      in_pins = v;
      {clamp_pins, panel_pins, ext_pins} = nc;
   endtask
endmodule // mdio_host
`default_nettype wire

// ===== bench/mdio_io_ctrl_test.sv
`default_nettype none
module mdio_io_ctrl_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 1, brake_fitted = 0, hold_enable = 0, notice_auto_clear = 1;
   logic rev_tick = 0, motor_moving = 0, torque_at_limit = 0, fault_trip = 0;
   logic hard_trip = 0, notice_event = 0, ready;
   logic [15:0] speed_cmd = 16'h0064, speed_act = 16'h0000, speed_width = 16'h0005;
   logic [1:0] clamp_pins, panel_pins, ext_pins, clamp_as = 2'h3, panel_as = 2'h3;
   logic [1:0] ext_as = 2'h3;
   logic [5:0] nc = 6'h3f;
   logic speed_pulse, alarm_out, shaft_turning, torque_limit_reached, speed_match;
   logic notice_flag, torque_clamp, panel_permit, brake_open, excite_off;
   mdio_pkg::mdio_in_s in_pins, p = '0;
   mdio_pkg::mdio_cmd_s motor_cmd;
   mdio_pkg::mdio_mode_e op_mode = mdio_pkg::MDIO_MODE_2W;
   int n_errors = 0, n_compared = 0, cyc = 0;
   mdio_host #(.NTERM(2), .POWERUP_CYC(20)) u_mdio_host (.clk(clk), .rst(rst),
      .in_pins(in_pins), .clamp_pins(clamp_pins), .panel_pins(panel_pins),
      .ext_pins(ext_pins), .ready(ready));
   mdio_io_ctrl #(.TICKS_PER_REV(120), .POWERUP_CYC(20), .NTERM(2)) u_mdio_io_ctrl (
      .clk(clk), .rst(rst), .in_pins(in_pins), .clamp_pins(clamp_pins),
      .clamp_assigned(clamp_as), .panel_pins(panel_pins), .panel_assigned(panel_as),
      .ext_pins(ext_pins), .ext_assigned(ext_as), .op_mode(op_mode),
      .brake_fitted(brake_fitted), .hold_enable(hold_enable),
      .notice_auto_clear(notice_auto_clear), .rev_tick(rev_tick),
      .motor_moving(motor_moving), .torque_at_limit(torque_at_limit),
      .speed_cmd(speed_cmd), .speed_act(speed_act), .speed_width(speed_width),
      .fault_trip(fault_trip), .hard_trip(hard_trip), .notice_event(notice_event),
      .speed_pulse(speed_pulse), .alarm_out(alarm_out), .shaft_turning(shaft_turning),
      .torque_limit_reached(torque_limit_reached), .speed_match(speed_match),
      .notice_flag(notice_flag), .torque_clamp(torque_clamp), .panel_permit(panel_permit),
      .brake_open(brake_open), .excite_off(excite_off), .motor_cmd(motor_cmd));
   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end
   // hang guard, well above the longest expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // apply terminals, then wait past the three- to four-cycle answer (alarm reset and notice clear take four)
   task automatic pp();
      u_mdio_host.put(p, nc);
      tick(5);
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      tick(1);
      s = 0;
      tick(5);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic t_power();
      chk(alarm_out, 1'b0);
      while (!ready) tick(1);
      tick(5);
      chk(alarm_out, 1'b1);
      $display("done power");
   endtask
   task automatic t_two_wire();
      p.forward_run = 1; pp(); chk({motor_cmd.run, motor_cmd.reverse}, 2'h2);
      p = '0; p.backward_run = 1; pp(); chk({motor_cmd.run, motor_cmd.reverse}, 2'h3);
      p = '0; pp(); chk({motor_cmd.run, motor_cmd.stop}, mdio_pkg::MDIO_STOP_DECEL);
      p.backward_run = 1; p.stop_select = 1; pp(); p.backward_run = 0; pp();
      chk({motor_cmd.run, motor_cmd.stop}, mdio_pkg::MDIO_STOP_INSTANT);
      op_mode = mdio_pkg::MDIO_MODE_2W1; p = '0; p.forward_run = 1; pp();
      p.backward_run = 1; pp(); chk({motor_cmd.run, motor_cmd.stop}, mdio_pkg::MDIO_STOP_DECEL);
      p = '0; pp();
      $display("done two wire");
   endtask
   task automatic t_three_wire();
      op_mode = mdio_pkg::MDIO_MODE_3W; p.forward_run = 1; pp();
      chk(motor_cmd.run, 1'b0);
      p = '0; p.decel_run_gate = 1; p.brake_run_gate = 1; p.turn_sense_select = 1; pp();
      chk({motor_cmd.run, motor_cmd.reverse}, 2'h3);
      p.turn_sense_select = 0; pp(); chk({motor_cmd.run, motor_cmd.reverse}, 2'h2);
      p.decel_run_gate = 0; pp(); chk({motor_cmd.run, motor_cmd.stop}, mdio_pkg::MDIO_STOP_DECEL);
      p.decel_run_gate = 1; pp(); p.brake_run_gate = 0; pp();
      chk({motor_cmd.run, motor_cmd.stop}, mdio_pkg::MDIO_STOP_INSTANT);
      op_mode = mdio_pkg::MDIO_MODE_2W; p = '0; pp();
      for (int i = 0; i < 16; i++) begin
         p.data_sel = 4'(i); pp(); chk(motor_cmd.data_no, 16'(i));
      end
      $display("done three wire and data select");
   endtask
   task automatic t_status();
      torque_at_limit = 1; speed_act = 16'h0069; motor_moving = 1; p.forward_run = 1; pp();
      chk({torque_limit_reached, speed_match, shaft_turning}, 3'h7);
      torque_at_limit = 0; speed_act = 16'h006a; motor_moving = 0; p.forward_run = 0; pp();
      chk({torque_limit_reached, speed_match, shaft_turning}, 3'h0);
      // one clamp and one panel terminal off; fault stop terminals left on
      nc = 6'h1b; pp(); chk({torque_clamp, panel_permit}, 2'h0);
      clamp_as = 2'h1; panel_as = 2'h2; pp(); chk({torque_clamp, panel_permit}, 2'h3);
      clamp_as = 2'h3; panel_as = 2'h3; nc = 6'h3f; pp();
      chk({torque_clamp, panel_permit}, 2'h3);
      notice_auto_clear = 0; pulse(notice_event); chk(notice_flag, 1'b1);
      p.notice_clear = 1; pp(); chk(notice_flag, 1'b0);
      p.notice_clear = 0; brake_fitted = 1; hold_enable = 1; p.brake_release = 1; pp();
      chk(brake_open, 1'b1);
      p.brake_release = 0; p.hold_release = 1; pp(); chk(excite_off, 1'b1);
      p.hold_release = 0; pp();
      $display("done status");
   endtask
   task automatic t_alarm();
      p.forward_run = 1; pp(); pulse(fault_trip);
      chk({alarm_out, motor_cmd.stop}, mdio_pkg::MDIO_STOP_COAST);
      p.alarm_reset = 1; pp(); chk(alarm_out, 1'b0);
      p = '0; pp(); p.alarm_reset = 1; pp(); chk(alarm_out, 1'b1);
      p = '0; p.forward_run = 1; pp(); nc = 6'h3e; pp();
      chk({alarm_out, motor_cmd.stop}, mdio_pkg::MDIO_STOP_INSTANT);
      nc = 6'h3f; p = '0; pp(); p.alarm_reset = 1; pp(); chk(alarm_out, 1'b1);
      p = '0; pp();
      $display("done alarm");
   endtask
   task automatic t_pulse();
      int w;
      repeat (3) pulse(rev_tick);
      chk(speed_pulse, 1'b0);
      pulse(rev_tick);
      w = 4;
      while (speed_pulse === 1'b1 && w < 60000) begin
         tick(1);
         w++;
      end
      chk(16'(w), 16'(50000));
      hard_trip = 1; tick(1); hard_trip = 0; p.alarm_reset = 1; pp(); p = '0; pp();
      chk(alarm_out, 1'b0);
      p.brake_release = 1; pp(); chk(brake_open, 1'b0);
      $display("done pulse and hard alarm");
   endtask
   task automatic finish_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // main sequence: reset for three cycles, then each scenario
   initial begin
      tick(3);
      rst = 0;
      tick(1);
      t_power();
      t_two_wire();
      t_three_wire();
      t_status();
      t_alarm();
      t_pulse();
      finish_test();
   end
endmodule // mdio_io_ctrl_test
`default_nettype wire

// ===== core/mdio_io_ctrl.sv
// Operation
// - thirty speed pulses per shaft turn
// - alarm output drops on any trip
// - shaft_turning only when operation input rotates
// - torque_limit_reached when torque hits limit
// - speed_match within detection width of command
// - outputs valid, inputs taken after 0.5 s; speed_pulse, notice_flag, torque_clamp, panel_permit not held
// - setting selects two-wire or three-wire mode
// - two-wire forward and backward run inputs
// - mode 1: both runs on decelerates; instant stop instead when stop_select on
// - stop_select picks decel or instant stop
// - three-wire runs only with both gates
// - turn_sense_select on means counterclockwise
// - four select bits give data number
// - alarm reset on edge, blocked while running
// - overcurrent and memory alarms not resettable
// - brake_release frees shaft, not under alarm
// - hold_release frees held shaft or brakes
// - torque clamp on limits, off peak
// - notice_clear edge clears when auto off
// - panel_unlock permits panel functions
// - external fault off alarms, instant stop
// - unassigned closed inputs on; multi-terminal and
// - speed pulse width fixed 0.2 ms
// - alarm coasts, external fault stops instantly
`include "mdio_params.svh"
`default_nettype none
module mdio_io_ctrl #(
   parameter int TICKS_PER_REV = `MDIO_TICKS_PER_REV,
   parameter int POWERUP_CYC = `MDIO_POWERUP_MS * `MDIO_CLK_MHZ * 1000,
   parameter int NTERM = 2
) (
   input wire logic clk, // 250 MHz
   input wire logic rst, // async, high
   input wire mdio_pkg::mdio_in_s in_pins, // input terminals
   input wire logic [NTERM-1:0] clamp_pins, // torque clamp terminals
   input wire logic [NTERM-1:0] clamp_assigned, // which are mapped
   input wire logic [NTERM-1:0] panel_pins, // panel unlock terminals
   input wire logic [NTERM-1:0] panel_assigned, // which are mapped
   input wire logic [NTERM-1:0] ext_pins, // fault stop terminals
   input wire logic [NTERM-1:0] ext_assigned, // which are mapped
   input wire mdio_pkg::mdio_mode_e op_mode, // setting 1819
   input wire logic brake_fitted, // brake-equipped driver
   input wire logic hold_enable, // load holding on
   input wire logic notice_auto_clear, // auto clear of notices
   input wire logic rev_tick, // one encoder tick
   input wire logic motor_moving, // shaft rotating
   input wire logic torque_at_limit, // torque reached limit
   input wire logic [15:0] speed_cmd, // commanded speed
   input wire logic [15:0] speed_act, // detected speed
   input wire logic [15:0] speed_width, // detection width
   input wire logic fault_trip, // resettable protective trip
   input wire logic hard_trip, // overcurrent / memory error
   input wire logic notice_event, // information raised
   output logic speed_pulse, // speed pulse output
   output logic alarm_out, // normally closed alarm
   output logic shaft_turning, // motion output
   output logic torque_limit_reached, // torque limit output
   output logic speed_match, // speed reached output
   output logic notice_flag, // information output
   output logic torque_clamp, // torque limit active
   output logic panel_permit, // panel functions allowed
   output logic brake_open, // brake released
   output logic excite_off, // excitation removed
   output mdio_pkg::mdio_cmd_s motor_cmd // command to power stage
);
   localparam int PW_CYC = `MDIO_PULSE_WIDTH_US * `MDIO_CLK_MHZ;
   localparam int TPP = TICKS_PER_REV / `MDIO_PULSES_PER_REV;
   localparam int W = 14 + 3 * NTERM;

   // all terminals through two flops; stage one is read only by stage two
   logic [W-1:0] raw, s1_q, s2_q;
   assign raw = {in_pins, clamp_pins, panel_pins, ext_pins};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   mdio_pkg::mdio_in_s si;
   logic [NTERM-1:0] clamp_s, panel_s, ext_s;
   assign {si, clamp_s, panel_s, ext_s} = s2_q;

   // unassigned terminal reads as on; a multi-mapped function needs all on
   function automatic logic all_on(input logic [NTERM-1:0] p, input logic [NTERM-1:0] a);
      all_on = &(p | ~a);
   endfunction

   logic clamp_on, panel_on, ext_on;
   assign clamp_on = all_on(clamp_s, clamp_assigned);
   assign panel_on = all_on(panel_s, panel_assigned);
   assign ext_on = all_on(ext_s, ext_assigned);

   // power-up window; run, reset, clear, brake and hold inputs ignored and outputs but speed_pulse, notice_flag, torque_clamp, panel_permit held safe
   logic [31:0] pu_cnt_q;
   logic ready_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pu_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (!ready_q) begin
         pu_cnt_q <= pu_cnt_q + 32'h1;
         ready_q <= (pu_cnt_q >= 32'(POWERUP_CYC - 2));
      end
   end

   // edge history for reset and clear inputs, taken on synced samples
   logic ar_prev_q, nc_prev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ar_prev_q <= 1'b0;
         nc_prev_q <= 1'b0;
      end else begin
         ar_prev_q <= si.alarm_reset;
         nc_prev_q <= si.notice_clear;
      end
   end
   logic ar_rise, nc_rise;
   assign ar_rise = si.alarm_reset & ~ar_prev_q & ready_q;
   assign nc_rise = si.notice_clear & ~nc_prev_q & ready_q;

   // run decode per mode
   logic three_w, run_req, back_req, both_2w, busy;
   assign three_w = (op_mode == mdio_pkg::MDIO_MODE_3W);
   assign both_2w = si.forward_run & si.backward_run;
   always_comb begin
      if (three_w) begin
         run_req = si.decel_run_gate & si.brake_run_gate;
         back_req = si.turn_sense_select;
         busy = run_req;
      end else begin
         run_req = si.forward_run ^ si.backward_run;
         if (op_mode == mdio_pkg::MDIO_MODE_2W1 && both_2w) begin
            run_req = 1'b0;
         end else if (both_2w) begin
            run_req = 1'b1; // plain two-wire: forward wins
         end
         back_req = ~si.forward_run & si.backward_run;
         busy = si.forward_run | si.backward_run;
      end
   end

   // alarm latch: trip sets; reset edge clears soft alarms only
   logic alarm_q, hard_q, ext_alarm_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_q <= 1'b0;
         hard_q <= 1'b0;
         ext_alarm_q <= 1'b0;
      end else begin
         if (hard_trip) begin
            hard_q <= 1'b1;
         end
         if (fault_trip || hard_trip || (ready_q && !ext_on)) begin
            alarm_q <= 1'b1;
            if (ready_q && !ext_on) begin
               ext_alarm_q <= 1'b1;
            end
         end else if (ar_rise && !busy && !hard_q) begin
            alarm_q <= 1'b0;
            ext_alarm_q <= 1'b0;
         end
      end
   end

   // motion command; alarm overrides run
   mdio_pkg::mdio_cmd_s cmd_d;
   always_comb begin
      cmd_d.data_no = si.data_sel;
      cmd_d.reverse = back_req;
      cmd_d.run = 1'b0;
      cmd_d.stop = mdio_pkg::MDIO_STOP_DECEL;
      if (!ready_q) begin
         cmd_d.stop = mdio_pkg::MDIO_STOP_NONE;
      end else if (alarm_q || !ext_on) begin
         cmd_d.stop = (ext_alarm_q || !ext_on) ? mdio_pkg::MDIO_STOP_INSTANT
                                               : mdio_pkg::MDIO_STOP_COAST;
      end else if (run_req) begin
         cmd_d.run = 1'b1;
         cmd_d.stop = mdio_pkg::MDIO_STOP_NONE;
      end else if (three_w) begin
         cmd_d.stop = si.brake_run_gate ? mdio_pkg::MDIO_STOP_DECEL
                                        : mdio_pkg::MDIO_STOP_INSTANT;
      end else begin
         cmd_d.stop = si.stop_select ? mdio_pkg::MDIO_STOP_INSTANT
                                     : mdio_pkg::MDIO_STOP_DECEL;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         motor_cmd <= '0;
      end else begin
         motor_cmd <= cmd_d;
      end
   end

   // speed pulse: tick divider and fixed-width stretcher
   logic [15:0] tick_q;
   logic [15:0] pw_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
         pw_q <= '0;
      end else begin
         if (pw_q != 16'h0) begin
            pw_q <= pw_q - 16'h1;
         end
         if (rev_tick) begin
            if (tick_q >= 16'(TPP - 1)) begin
               tick_q <= '0;
               pw_q <= 16'(PW_CYC);
            end else begin
               tick_q <= tick_q + 16'h1;
            end
         end
      end
   end

   // speed window compare
   logic [16:0] diff;
   assign diff = (speed_act >= speed_cmd) ? {1'b0, speed_act - speed_cmd}
                                          : {1'b0, speed_cmd - speed_act};

   // notice latch; a new event in the clear cycle wins
   logic notice_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         notice_q <= 1'b0;
      end else if (notice_event) begin
         notice_q <= 1'b1;
      end else if (notice_auto_clear || nc_rise) begin
         notice_q <= 1'b0;
      end
   end

   // brake and hold; brake release refused under alarm
   logic still;
   assign still = ~motor_moving & ~cmd_d.run;

   // registered outputs; safe values through the power-up window except speed_pulse, notice_flag, torque_clamp and panel_permit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         speed_pulse <= 1'b0;
         alarm_out <= 1'b0;
         shaft_turning <= 1'b0;
         torque_limit_reached <= 1'b0;
         speed_match <= 1'b0;
         notice_flag <= 1'b0;
         torque_clamp <= 1'b1;
         panel_permit <= 1'b0;
         brake_open <= 1'b0;
         excite_off <= 1'b0;
      end else begin
         speed_pulse <= (pw_q != 16'h0);
         alarm_out <= ready_q & ~alarm_q;
         shaft_turning <= ready_q & motor_moving & cmd_d.run;
         torque_limit_reached <= ready_q & torque_at_limit;
         speed_match <= ready_q & (diff <= {1'b0, speed_width});
         notice_flag <= notice_q;
         torque_clamp <= clamp_on;
         panel_permit <= panel_on;
         brake_open <= brake_fitted & ready_q & still & si.brake_release
                       & ~alarm_q;
         excite_off <= still & hold_enable & si.hold_release & ready_q;
      end
   end

   a_alarm_drop: assert property (@(posedge clk) disable iff (rst)
      (fault_trip || hard_trip) |=> ##2 !alarm_out)
      else $error("alarm output stayed on after trip");
   a_hard_keep: assert property (@(posedge clk) disable iff (rst)
      hard_q |=> alarm_q)
      else $error("hard alarm was cleared");
   a_pulse_width: assert property (@(posedge clk) disable iff (rst)
      $rose(speed_pulse) |-> speed_pulse [*8])
      else $error("speed pulse too short");
   a_brake_alarm: assert property (@(posedge clk) disable iff (rst)
      alarm_q |=> !brake_open)
      else $error("brake released under alarm");
   a_run_3w: assert property (@(posedge clk) disable iff (rst)
      (three_w && !(si.decel_run_gate && si.brake_run_gate)) |=> !motor_cmd.run)
      else $error("three-wire ran without both gates");
   a_both_2w1: assert property (@(posedge clk) disable iff (rst)
      (op_mode == mdio_pkg::MDIO_MODE_2W1 && both_2w) |=> !motor_cmd.run)
      else $error("mode 1 ran with both inputs");
   a_ext_stop: assert property (@(posedge clk) disable iff (rst)
      (ready_q && !ext_on) |=> motor_cmd.stop == mdio_pkg::MDIO_STOP_INSTANT)
      else $error("external fault did not stop instantly");
   a_powerup_out: assert property (@(posedge clk) disable iff (rst)
      !ready_q |=> !alarm_out && !motor_cmd.run)
      else $error("output valid before power-up time");
   a_data_no: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> motor_cmd.data_no == $past(si.data_sel))
      else $error("data number wrong");
endmodule : mdio_io_ctrl
`default_nettype wire

// ===== core/mdio_params.svh
`ifndef MDIO_PARAMS_SVH
`define MDIO_PARAMS_SVH
// speed pulse output: pulses per shaft turn, width in microseconds
`define MDIO_PULSES_PER_REV 30
`define MDIO_PULSE_WIDTH_US 200
// power-up validity time in milliseconds
`define MDIO_POWERUP_MS 500
// clock rate in MHz
`define MDIO_CLK_MHZ 250
// encoder ticks per shaft turn (default)
`define MDIO_TICKS_PER_REV 3000
`endif

// ===== core/mdio_pkg.sv
`default_nettype none
package mdio_pkg;
   // operation input mode (setting 1819)
   typedef enum logic [1:0] {
      MDIO_MODE_2W,
      MDIO_MODE_2W1,
      MDIO_MODE_3W
   } mdio_mode_e;

   // stop style handed to the power stage
   typedef enum logic [1:0] {
      MDIO_STOP_NONE,
      MDIO_STOP_DECEL,
      MDIO_STOP_INSTANT,
      MDIO_STOP_COAST
   } mdio_stop_e;

   // raw input terminals
   typedef struct packed {
      logic forward_run;
      logic backward_run;
      logic stop_select;
      logic decel_run_gate;
      logic brake_run_gate;
      logic turn_sense_select;
      logic [3:0] data_sel;
      logic alarm_reset;
      logic brake_release;
      logic hold_release;
      logic notice_clear;
   } mdio_in_s;

   // motion command to the power stage
   typedef struct packed {
      logic run;
      logic reverse;
      mdio_stop_e stop;
      logic [3:0] data_no;
   } mdio_cmd_s;
endpackage : mdio_pkg
`default_nettype wire
